//--- serial_irq_ctrl.sv
// Serial interrupt controller registers with memory window and configuration space access.
//
// Contract
// - Start width code 00/01/10 gives 4/6/8 clocks; 11 is reserved.
// - Polling select 0 runs frames continuously, 1 runs quiet mode.
// - Recovery drive select 0 drives line high in recovery, 1 tri-states it.
// - Mode control bits 7:4 read zero and ignore writes.
// - One trigger-type bit per interrupt 0..15: 0 edge, 1 level.
// - A level interrupt seen on the stream sets its status bit.
// - Writing 1 to a status bit clears it and re-arms that interrupt.
// - Edge-mode interrupts never set a status bit.
// - Link, global and power-on reset clear all configuration bits to zero.
// - Memory window and configuration space copies share the same storage.
// - Status register reads all zeros after reset.
`timescale 1ns/1ps
`default_nettype none
`include "serirq_defines.svh"

module serial_irq_ctrl
    import serirq_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_arst_n,
    input  wire logic        i_link_reset,
    input  wire logic        i_global_reset,
    input  wire logic [7:0]  i_mw_addr,
    input  wire logic        i_mw_wr,
    input  wire logic        i_mw_rd,
    input  wire logic [1:0]  i_mw_be,
    input  wire logic [15:0] i_mw_wdata,
    output logic [15:0]      o_mw_rdata,
    input  wire logic [7:0]  i_cfg_addr,
    input  wire logic        i_cfg_wr,
    input  wire logic        i_cfg_rd,
    input  wire logic [1:0]  i_cfg_be,
    input  wire logic [15:0] i_cfg_wdata,
    output logic [15:0]      o_cfg_rdata,
    input  wire logic        i_serirq,
    output logic             o_serirq,
    output logic             o_serirq_oe,
    output logic [15:0]      o_irq_request
);

    // ======================================================================
    // Declarations
    // ======================================================================
    logic        rst_meta_q;
    logic        rst_n_q;
    logic [1:0]  lrst_sync_q;
    logic [1:0]  global_reset_sync_q;
    logic [1:0]  line_sync_q;
    logic        soft_clear;

    logic [3:0]  mode_q;
    logic [3:0]  mode_d;
    logic [15:0] trig_q;
    logic [15:0] trig_d;
    logic [15:0] stat_q;
    logic [15:0] stat_d;

    logic        mw_mode_hit;
    logic        mw_trig_hit;
    logic        mw_stat_hit;
    logic        cfg_mode_hit;
    logic        cfg_trig_hit;
    logic        cfg_stat_hit;

    logic [15:0] mw_wmask;
    logic [15:0] cfg_wmask;
    logic [15:0] mw_wbits;
    logic [15:0] cfg_wbits;
    logic [15:0] stat_clear;
    logic [15:0] stat_set;
    logic [15:0] mw_rword;
    logic [15:0] cfg_rword;
    logic [15:0] mode_word;

    logic        slot_valid;
    logic [3:0]  slot_index;
    logic        slot_low;

    // ======================================================================
    // Reset release and input synchronisers
    // ======================================================================
    // The external reset is released through two flip-flops so that every
    // register leaves reset on the same clean edge.
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // Link reset, global reset and the shared line arrive from pins, so each
    // passes two flip-flops before any logic reads it.
    always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            lrst_sync_q <= 2'h0;
            global_reset_sync_q <= 2'h0;
            line_sync_q <= 2'h3;
        end else begin
            lrst_sync_q <= {lrst_sync_q[0], i_link_reset};
            global_reset_sync_q <= {global_reset_sync_q[0], i_global_reset};
            line_sync_q <= {line_sync_q[0], i_serirq};
        end
    end

    // Either synchronous reset source wipes configuration and status.
    assign soft_clear = lrst_sync_q[1] | global_reset_sync_q[1];

    // ======================================================================
    // Address decode for both access paths
    // ======================================================================
    // Both paths decode onto one set of registers; bit 0 of the address is
    // ignored because every register is a halfword.
    assign mw_mode_hit  = (i_mw_addr[7:1] == 7'(`SIRQ_MW_MODE_OFS >> 1));
    assign mw_trig_hit  = (i_mw_addr[7:1] == 7'(`SIRQ_MW_TRIG_OFS >> 1));
    assign mw_stat_hit  = (i_mw_addr[7:1] == 7'(`SIRQ_MW_STAT_OFS >> 1));
    assign cfg_mode_hit = (i_cfg_addr[7:1] == 7'(`SIRQ_CFG_MODE_OFS >> 1));
    assign cfg_trig_hit = (i_cfg_addr[7:1] == 7'(`SIRQ_CFG_TRIG_OFS >> 1));
    assign cfg_stat_hit = (i_cfg_addr[7:1] == 7'(`SIRQ_CFG_STAT_OFS >> 1));

    // Byte enables expand to a bit mask for each path.
    assign mw_wmask  = {{8{i_mw_be[1]}}, {8{i_mw_be[0]}}};
    assign cfg_wmask = {{8{i_cfg_be[1]}}, {8{i_cfg_be[0]}}};
    assign mw_wbits  = i_mw_wdata & mw_wmask;
    assign cfg_wbits = i_cfg_wdata & cfg_wmask;

    // ======================================================================
    // Configuration register next values
    // ======================================================================
    // A configuration write lands first and a memory window write on the
    // same cycle overrides it, so simultaneous writes resolve predictably.
    always_comb begin
        mode_d = mode_q;
        trig_d = trig_q;
        if (i_cfg_wr && cfg_mode_hit && i_cfg_be[0]) begin
            mode_d = i_cfg_wdata[`SIRQ_MODE_BITS-1:0];
        end
        if (i_mw_wr && mw_mode_hit && i_mw_be[0]) begin
            mode_d = i_mw_wdata[`SIRQ_MODE_BITS-1:0];
        end
        if (i_cfg_wr && cfg_trig_hit) begin
            trig_d = (trig_d & ~cfg_wmask) | cfg_wbits;
        end
        if (i_mw_wr && mw_trig_hit) begin
            trig_d = (trig_d & ~mw_wmask) | mw_wbits;
        end
    end

    // ======================================================================
    // Status bits, one generate slice per interrupt
    // ======================================================================
    // A write of 1 from either path clears the bit.
    assign stat_clear = ({16{i_mw_wr && mw_stat_hit}} & mw_wbits) |
                        ({16{i_cfg_wr && cfg_stat_hit}} & cfg_wbits);

    genvar n;
    generate
        for (n = 0; n < 16; n = n + 1) begin : g_status
            // Only level-mode interrupts are reported; edge mode never sets.
            assign stat_set[n] = slot_valid && slot_low && trig_q[n] &&
                                 (slot_index == 4'(n));
            // A slot sample arriving with the clear keeps the bit set, so a
            // re-assertion during software's write-back is never lost.
            assign stat_d[n]   = stat_set[n] | (stat_q[n] & ~stat_clear[n]);
        end
    endgenerate

    // ======================================================================
    // Register storage
    // ======================================================================
    always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mode_q <= `SIRQ_MODE_RESET;
            trig_q <= `SIRQ_TRIG_RESET;
            stat_q <= `SIRQ_STAT_RESET;
        end else if (soft_clear) begin
            mode_q <= `SIRQ_MODE_RESET;
            trig_q <= `SIRQ_TRIG_RESET;
            stat_q <= `SIRQ_STAT_RESET;
        end else begin
            mode_q <= mode_d;
            trig_q <= trig_d;
            stat_q <= stat_d;
        end
    end

    // ======================================================================
    // Read data selection
    // ======================================================================
    // The upper nibble of mode control and the unused high byte are zero.
    assign mode_word = {12'h000, mode_q};

    assign mw_rword  = mw_mode_hit  ? mode_word :
                       mw_trig_hit  ? trig_q    :
                       mw_stat_hit  ? stat_q    : 16'h0000;
    assign cfg_rword = cfg_mode_hit ? mode_word :
                       cfg_trig_hit ? trig_q    :
                       cfg_stat_hit ? stat_q    : 16'h0000;

    // Read data is registered and held until the next read on that path.
    // Disabled byte lanes return zero so a byte read cannot see its neighbour.
    always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_mw_rdata  <= 16'h0000;
            o_cfg_rdata <= 16'h0000;
        end else begin
            if (i_mw_rd) begin
                o_mw_rdata <= mw_rword & mw_wmask;
            end
            if (i_cfg_rd) begin
                o_cfg_rdata <= cfg_rword & cfg_wmask;
            end
        end
    end

    // ======================================================================
    // Frame sequencer
    // ======================================================================
    // The sequencer reads mode control live; a change mid-frame takes effect
    // at the next start or stop decision, which keeps it free of extra copies.
    serirq_frame u_frame (
        .i_clk_sys          (i_clk_sys),
        .i_rst_n            (rst_n_q),
        .i_line             (line_sync_q[1]),
        .i_start_code       (mode_q[`SIRQ_WIDTH_MSB:`SIRQ_WIDTH_LSB]),
        .i_quiet            (mode_q[`SIRQ_POLL_BIT]),
        .i_recover_tristate (mode_q[`SIRQ_DRIVE_BIT]),
        .o_line             (o_serirq),
        .o_line_oe          (o_serirq_oe),
        .o_slot_valid       (slot_valid),
        .o_slot_index       (slot_index),
        .o_slot_low         (slot_low)
    );

    // ======================================================================
    // Per-interrupt request outputs
    // ======================================================================
    // Each request follows the last sample of its slot, active high, for
    // both edge and level interrupts; the downstream controller decides.
    always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_irq_request <= 16'h0000;
        end else if (slot_valid) begin
            o_irq_request[slot_index] <= slot_low;
        end
    end

endmodule // serial_irq_ctrl
`default_nettype wire

//--- serial_irq_ctrl_props.sv
// Port-level assertions for the serial interrupt controller.
`timescale 1ns/1ps
`default_nettype none

module serial_irq_ctrl_props (
    input wire logic        i_clk_sys,
    input wire logic        i_arst_n,
    input wire logic        i_link_reset,
    input wire logic        i_global_reset,
    input wire logic [7:0]  i_mw_addr,
    input wire logic        i_mw_rd,
    input wire logic [15:0] o_mw_rdata,
    input wire logic [7:0]  i_cfg_addr,
    input wire logic        i_cfg_rd,
    input wire logic [15:0] o_cfg_rdata,
    input wire logic        o_serirq,
    input wire logic        o_serirq_oe,
    input wire logic [15:0] o_irq_request
);
    // ======================================================================
    // Helper logic
    logic       low_w;
    logic       soft_w;
    logic [3:0] run_q;
    logic [3:0] soft_q;
    // Soft resets land late through their synchronisers, so read checks wait them out.
    assign low_w  = o_serirq_oe && !o_serirq;
    assign soft_w = i_link_reset || i_global_reset || soft_q != 4'h0;
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            run_q  <= 4'h0;
            soft_q <= 4'h0;
        end else begin
            run_q  <= low_w ? run_q + 4'h1 : 4'h0;
            soft_q <= {soft_q[2:0], i_link_reset || i_global_reset};
        end
    end
    // ======================================================================
    // Assertions
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);
    run_max_a: assert property (low_w |-> run_q < 4'h8)
        else $error("Low run too long");
    run_len_a: assert property (!low_w && run_q != 4'h0 |-> run_q inside {4'h2, 4'h3, 4'h4, 4'h6, 4'h8})
        else $error("Bad low run length");
    recov_high_a: assert property (low_w ##1 (o_serirq_oe && o_serirq) |=> !o_serirq_oe)
        else $error("No turnaround after recovery");
    turn_gap_a: assert property ($fell(o_serirq_oe) |-> !o_serirq_oe ##1 !o_serirq_oe)
        else $error("Line retaken too soon");
    rdata_hold_a: assert property (disable iff (!i_arst_n || soft_w) !i_mw_rd |=> $stable(o_mw_rdata))
        else $error("Read data moved without a read");
    mode_reserved_bits_a: assert property (i_mw_rd && i_mw_addr[7:1] == 7'h24 |=> o_mw_rdata[15:4] == 12'h000)
        else $error("Reserved mode bits not zero");
    alias_read_a: assert property (i_mw_rd && i_cfg_rd && i_cfg_addr == i_mw_addr + 8'h98 |=>
        o_mw_rdata == o_cfg_rdata) else $error("Alias paths disagree");
    reset_rel_a: assert property ($rose(i_arst_n) |-> !o_serirq_oe && o_irq_request == 16'h0000)
        else $error("Outputs not at reset values");
    cover property (low_w && run_q == 4'h7);
    cover property (o_irq_request != 16'h0000);
    cover property ($fell(soft_w));
endmodule // serial_irq_ctrl_props

bind serial_irq_ctrl serial_irq_ctrl_props u_props (
    .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_link_reset(i_link_reset), .i_global_reset(i_global_reset),
    .i_mw_addr(i_mw_addr), .i_mw_rd(i_mw_rd), .o_mw_rdata(o_mw_rdata), .i_cfg_addr(i_cfg_addr),
    .i_cfg_rd(i_cfg_rd), .o_cfg_rdata(o_cfg_rdata), .o_serirq(o_serirq), .o_serirq_oe(o_serirq_oe),
    .o_irq_request(o_irq_request)
);
`default_nettype wire

//--- serial_irq_ctrl_tb_top.sv
// Self-checking testbench for the serial interrupt controller with a peripheral model.
`timescale 1ns/1ps
`default_nettype none

module serial_irq_ctrl_tb_top;
    logic        i_clk_sys, i_arst_n, i_link_reset, i_global_reset, i_serirq, o_serirq, o_serirq_oe;
    logic        i_mw_wr, i_mw_rd, i_cfg_wr, i_cfg_rd, pull_low, tristate, busy;
    logic [1:0]  i_mw_be, i_cfg_be;
    logic [7:0]  i_mw_addr, i_cfg_addr, cur_mode;
    logic [15:0] i_mw_wdata, i_cfg_wdata, o_mw_rdata, o_cfg_rdata, o_irq_request, req, r, t, rq, w, n;
    int          num_errors = 0;
    int          check_count = 0;
    serial_irq_ctrl u_dut (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_link_reset(i_link_reset),
        .i_global_reset(i_global_reset), .i_mw_addr(i_mw_addr), .i_mw_wr(i_mw_wr), .i_mw_rd(i_mw_rd),
        .i_mw_be(i_mw_be), .i_mw_wdata(i_mw_wdata), .o_mw_rdata(o_mw_rdata), .i_cfg_addr(i_cfg_addr),
        .i_cfg_wr(i_cfg_wr), .i_cfg_rd(i_cfg_rd), .i_cfg_be(i_cfg_be), .i_cfg_wdata(i_cfg_wdata),
        .o_cfg_rdata(o_cfg_rdata), .i_serirq(i_serirq), .o_serirq(o_serirq), .o_serirq_oe(o_serirq_oe),
        .o_irq_request(o_irq_request));
    serirq_peripheral u_periph (.i_clk_sys(i_clk_sys), .i_rst_n(i_arst_n), .i_host_oe(o_serirq_oe),
        .i_tristate(tristate), .i_req(req), .o_pull_low(pull_low));
    // Pulled-up line: the host wins while it drives.
    assign i_serirq = o_serirq_oe ? o_serirq : !pull_low;
    initial begin
        i_clk_sys = 1'b0;
        forever #12.5 i_clk_sys = ~i_clk_sys;
    end
    // ======================================================================
    // Tasks
    task automatic summarize();
        $display("Checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Reads hit both paths at once so the alias check always sees a pair.
    task automatic acc(input logic cfg, input logic wr, input logic [7:0] ofs, input logic [15:0] wd);
        @(negedge i_clk_sys);
        {i_mw_addr, i_cfg_addr, i_mw_wdata, i_cfg_wdata} = {ofs, ofs + 8'h98, wd, wd};
        {i_mw_wr, i_cfg_wr, i_mw_rd, i_cfg_rd} = {wr & !cfg, wr & cfg, !wr, !wr};
        @(negedge i_clk_sys);
        {i_mw_wr, i_cfg_wr, i_mw_rd, i_cfg_rd} = 4'h0;
        @(negedge i_clk_sys);
        r = cfg ? o_cfg_rdata : o_mw_rdata;
    endtask
    task automatic rchk(input logic cfg, input logic [7:0] ofs, input logic [15:0] exp);
        acc(cfg, 1'b0, ofs, 16'h0000);
        chk(r, exp);
    endtask
    // Park in quiet mode before any change so no frame is cut by a live edit.
    task automatic set_mode(input logic [7:0] v);
        acc(1'b0, 1'b1, 8'h48, {8'h00, cur_mode | 8'h02});
        repeat (80) @(negedge i_clk_sys);
        busy = 1'b0;
        repeat (60) begin
            @(negedge i_clk_sys);
            busy = busy | o_serirq_oe;
        end
        chk(busy, 1'b0);
        cur_mode = v;
        tristate = v[0];
        acc(1'b0, 1'b1, 8'h48, {8'h00, v});
    endtask
    function automatic logic [15:0] exp_width(input logic [1:0] code);
        return (code == 2'h1) ? 16'h0006 : (code == 2'h2) ? 16'h0008 : 16'h0004;
    endfunction
    // ======================================================================
    // Tests
    initial begin
        void'($urandom(91));
        {i_arst_n, i_link_reset, i_global_reset, i_mw_wr, i_mw_rd, i_cfg_wr, i_cfg_rd} = 7'h00;
        {i_mw_addr, i_cfg_addr, i_mw_wdata, i_cfg_wdata, req, cur_mode, tristate} = 73'h0;
        {i_mw_be, i_cfg_be} = 4'hF;
        repeat (6) @(negedge i_clk_sys);
        i_arst_n = 1'b1;
        repeat (5) @(negedge i_clk_sys);
        for (int i = 0; i < 6; i++) rchk(i[0], 8'h48 + 8'(2 * (i / 2)), 16'h0000);
        rchk(1'b1, 8'h4E, 16'h0000);
        $display("reset test done");
        acc(1'b1, 1'b1, 8'h48, 16'hFFF3);
        {cur_mode, tristate} = 9'h007;
        rchk(1'b0, 8'h48, 16'h0003);
        t = 16'($urandom);
        acc(1'b0, 1'b1, 8'h4A, t);
        rchk(1'b1, 8'h4A, t);
        $display("register test done");
        for (int i = 0; i < 4; i++) begin
            set_mode({4'h0, 2'(i), 1'b0, i[0]});
            n = 16'h0000;
            for (int k = 0; k < 20 && !(o_serirq_oe && !o_serirq); k++) @(negedge i_clk_sys);
            while (o_serirq_oe && !o_serirq) begin
                n++;
                @(negedge i_clk_sys);
            end
            chk(n, exp_width(2'(i)));
            chk({o_serirq_oe, o_serirq | i[0]}, {!i[0], 1'b1});
        end
        $display("frame test done");
        for (int i = 0; i < 3; i++) begin
            t = (i == 0) ? 16'hFFFF : 16'($urandom);
            rq = 16'($urandom) | 16'h8001;
            w = 16'($urandom);
            acc(i[0], 1'b1, 8'h4A, t);
            req = rq;
            repeat (150) @(negedge i_clk_sys);
            chk(o_irq_request, rq);
            rchk(1'b0, 8'h4C, rq & t);
            req = 16'h0000;
            repeat (150) @(negedge i_clk_sys);
            rchk(1'b1, 8'h4C, rq & t);
            acc(!i[0], 1'b1, 8'h4C, w);
            rchk(i[0], 8'h4C, rq & t & ~w);
            req = rq;
            repeat (150) @(negedge i_clk_sys);
            rchk(1'b0, 8'h4C, rq & t);
            req = 16'h0000;
            repeat (150) @(negedge i_clk_sys);
            acc(1'b0, 1'b1, 8'h4C, 16'hFFFF);
        end
        $display("status test done");
        for (int i = 0; i < 2; i++) begin
            acc(1'b0, 1'b1, 8'h48, 16'h000E);
            acc(1'b1, 1'b1, 8'h4A, 16'hA5C3);
            {i_global_reset, i_link_reset} = i[0] ? 2'h2 : 2'h1;
            repeat (4) @(negedge i_clk_sys);
            {i_global_reset, i_link_reset, tristate} = 3'h0;
            repeat (4) @(negedge i_clk_sys);
            rchk(1'b0, 8'h48, 16'h0000);
            rchk(1'b1, 8'h4A, 16'h0000);
        end
        $display("soft reset test done");
        summarize();
    end
    // A hang counts as a mismatch and closes the run the same way.
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        num_errors++;
        summarize();
    end
endmodule // serial_irq_ctrl_tb_top
`default_nettype wire

//--- serirq_defines.svh
// Offsets, field positions, reset values and frame timing counts of the serial interrupt controller.
`ifndef SERIRQ_DEFINES_SVH
`define SERIRQ_DEFINES_SVH

// ======================================================================
// Register offsets in the memory window and in configuration space
// ======================================================================
`define SIRQ_MW_MODE_OFS      8'h48
`define SIRQ_MW_TRIG_OFS      8'h4A
`define SIRQ_MW_STAT_OFS      8'h4C
`define SIRQ_CFG_MODE_OFS     8'hE0
`define SIRQ_CFG_TRIG_OFS     8'hE2
`define SIRQ_CFG_STAT_OFS     8'hE4

// ======================================================================
// Mode control field positions
// ======================================================================
`define SIRQ_DRIVE_BIT        0
`define SIRQ_POLL_BIT         1
`define SIRQ_WIDTH_LSB        2
`define SIRQ_WIDTH_MSB        3
`define SIRQ_MODE_BITS        4

// ======================================================================
// Reset values
// ======================================================================
`define SIRQ_MODE_RESET       4'h0
`define SIRQ_TRIG_RESET       16'h0000
`define SIRQ_STAT_RESET       16'h0000

// ======================================================================
// Start width codes and frame timing in clocks
// ======================================================================
`define SIRQ_WIDTH_CODE_4     2'h0
`define SIRQ_WIDTH_CODE_6     2'h1
`define SIRQ_WIDTH_CODE_8     2'h2
`define SIRQ_START_CLKS_4     4'h4
`define SIRQ_START_CLKS_6     4'h6
`define SIRQ_START_CLKS_8     4'h8
`define SIRQ_STOP_CLKS_QUIET  4'h2
`define SIRQ_STOP_CLKS_CONT   4'h3
`define SIRQ_SLOT_PHASES      2'h3
`define SIRQ_SAMPLE_PHASE     2'h2
`define SIRQ_LAST_SLOT        4'hF

`endif

//--- serirq_frame.sv
// Frame sequencer that drives start and stop frames and samples the sixteen interrupt slots.
`timescale 1ns/1ps
`default_nettype none
`include "serirq_defines.svh"

module serirq_frame
    import serirq_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_n,
    input  wire logic        i_line,
    input  wire start_code_t i_start_code,
    input  wire logic        i_quiet,
    input  wire logic        i_recover_tristate,
    output logic             o_line,
    output logic             o_line_oe,
    output logic             o_slot_valid,
    output logic [3:0]       o_slot_index,
    output logic             o_slot_low
);

    frame_state_e state_q;
    frame_state_e state_d;
    logic [3:0]   cnt_q;
    logic [3:0]   cnt_d;
    logic [3:0]   slot_q;
    logic [3:0]   slot_d;
    logic [3:0]   start_len;
    logic [3:0]   stop_len;
    logic         sample_now;

    // ======================================================================
    // Frame lengths
    // ======================================================================
    // The reserved width code falls back to the shortest start frame.
    assign start_len  = (i_start_code == `SIRQ_WIDTH_CODE_6) ? `SIRQ_START_CLKS_6 :
                        (i_start_code == `SIRQ_WIDTH_CODE_8) ? `SIRQ_START_CLKS_8 :
                        `SIRQ_START_CLKS_4;
    assign stop_len   = i_quiet ? `SIRQ_STOP_CLKS_QUIET : `SIRQ_STOP_CLKS_CONT;
    // The line input is two clocks late, so phase two still sees the line as it was in phase zero.
    assign sample_now = (state_q == ST_SLOT) && (cnt_q[1:0] == `SIRQ_SAMPLE_PHASE);

    // ======================================================================
    // Next-state logic
    // ======================================================================
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q + 4'h1;
        slot_d  = slot_q;
        case (state_q)
            ST_IDLE: begin
                cnt_d = 4'h0;
                // Quiet mode waits for a peripheral to pull the line low.
                if (!i_quiet || !i_line) begin
                    state_d = ST_START;
                end
            end
            // Lengths are compared with >= so a live mode change cannot overrun the count.
            ST_START: begin
                if (cnt_q >= start_len - 4'h1) begin
                    state_d = ST_SREC;
                end
            end
            ST_SREC: begin
                state_d = ST_TURN;
            end
            ST_TURN: begin
                state_d = ST_SLOT;
                cnt_d   = 4'h0;
                slot_d  = 4'h0;
            end
            ST_SLOT: begin
                if (cnt_q[1:0] == `SIRQ_SLOT_PHASES - 2'h1) begin
                    cnt_d  = 4'h0;
                    slot_d = slot_q + 4'h1;
                    if (slot_q == `SIRQ_LAST_SLOT) begin
                        state_d = ST_STOP;
                    end
                end
            end
            ST_STOP: begin
                if (cnt_q >= stop_len - 4'h1) begin
                    state_d = ST_PREC;
                end
            end
            ST_PREC: begin
                state_d = ST_PTURN;
            end
            ST_PTURN: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        if (state_d != state_q && state_q != ST_SLOT) begin
            cnt_d = 4'h0;
        end
    end

    // ======================================================================
    // State, pin drive and slot report registers
    // ======================================================================
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q      <= ST_IDLE;
            cnt_q        <= 4'h0;
            slot_q       <= 4'h0;
            o_line       <= 1'b1;
            o_line_oe    <= 1'b0;
            o_slot_valid <= 1'b0;
            o_slot_index <= 4'h0;
            o_slot_low   <= 1'b0;
        end else begin
            state_q      <= state_d;
            cnt_q        <= cnt_d;
            slot_q       <= slot_d;
            o_line       <= !(state_d == ST_START || state_d == ST_STOP);
            o_line_oe    <= (state_d == ST_START) || (state_d == ST_STOP) ||
                            (((state_d == ST_SREC) || (state_d == ST_PREC)) && !i_recover_tristate);
            o_slot_valid <= sample_now;
            o_slot_index <= slot_q;
            o_slot_low   <= !i_line;
        end
    end

endmodule // serirq_frame
`default_nettype wire

//--- serirq_peripheral.sv
// Behavioural model of the peripherals sharing the serial interrupt line.
`timescale 1ns/1ps
`default_nettype none

module serirq_peripheral (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_n,
    input  wire logic        i_host_oe,
    input  wire logic        i_tristate,
    input  wire logic [15:0] i_req,
    output logic             o_pull_low
);
    // ======================================================================
    // Slot tracking
    logic [7:0] cnt_q;
    logic [7:0] phase;
    logic       data_q;
    logic       oe_q;
    // A tri-stated recovery drops the enable one clock earlier, so slot zero is one count later.
    assign phase = cnt_q - (i_tristate ? 8'h02 : 8'h01);
    // Requesters pull only the first clock of their slot; the pull-up restores the line after.
    assign o_pull_low = data_q && !i_host_oe && phase < 8'h30 && phase % 8'h03 == 8'h00
                        && i_req[4'(phase / 8'h03)];
    // Count clocks since the host let go and tell data frames from stop frames.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q  <= 8'h00;
            data_q <= 1'b0;
            oe_q   <= 1'b0;
        end else begin
            cnt_q  <= i_host_oe ? 8'h00 : cnt_q + {7'h00, cnt_q != 8'hFF};
            data_q <= data_q ^ (oe_q && !i_host_oe);
            oe_q   <= i_host_oe;
        end
    end
endmodule // serirq_peripheral
`default_nettype wire

//--- serirq_pkg.sv
// Types shared by the serial interrupt controller files.
package serirq_pkg;

    // Frame sequencer states, Gray coded along the frame path.
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_START = 3'h1,
        ST_SREC  = 3'h3,
        ST_TURN  = 3'h2,
        ST_SLOT  = 3'h6,
        ST_STOP  = 3'h7,
        ST_PREC  = 3'h5,
        ST_PTURN = 3'h4
    } frame_state_e;

    typedef logic [1:0] start_code_t;

endpackage
